// [osdpl_device_end.sv]
// device end: serial receiver, page memory, frame control, display walker
// assumes link levels synchronous to core_clk, scl quarter of many cycles
`timescale 1ns/1ns
`include "osdpl_regs.svh"

module osdpl_device_end #(
    parameter int DEPTH = 512,
    parameter int AW = 9
) (
    // clock and reset
    input wire logic core_clk,
    input wire logic rst_b,
    // serial link
    osdpl_link_if.device link,
    // display walker control
    input wire logic scan_restart,
    input wire logic scan_step,
    // display walker result
    output logic [AW-1:0] scan_index,
    output osdpl_pkg::osdpl_kind_t scan_kind,
    output logic [7:0] scan_code,
    output logic [3:0] scan_attr,
    output logic [3:0] scan_skip,
    // control state
    output logic [7:0] frame_control_one,
    output logic page_cleared
);

    typedef struct packed {
        logic [DEPTH-1:0][11:0] ram;
        osdpl_pkg::osdpl_dev_st_t st;
        logic scl_q;
        logic sda_q;
        logic [3:0] bit_cnt;
        logic [7:0] shreg;
        logic [2:0] byte_idx;
        logic ack_pend;
        logic [15:0] addr;
        logic [3:0] attr;
        logic sda_oe_b;
        logic [7:0] fc;
        logic cleared;
        logic sl_pos;
        logic [AW-1:0] w_index;
        osdpl_pkg::osdpl_kind_t w_kind;
        logic [7:0] w_code;
        logic [3:0] w_attr;
        logic [3:0] w_skip;
    } osdpl_dev_state_t;

    osdpl_dev_state_t r;
    osdpl_dev_state_t next_r;

    // outputs straight from the state register; sda_dev_out tied low
    assign link.sda_dev_out = 1'b0;
    assign link.sda_dev_oe_b = r.sda_oe_b;
    assign scan_index = r.w_index;
    assign scan_kind = r.w_kind;
    assign scan_code = r.w_code;
    assign scan_attr = r.w_attr;
    assign scan_skip = r.w_skip;
    assign frame_control_one = r.fc;
    assign page_cleared = r.cleared;

    ////////////////////////////////////////////////////////////////////////
    // next state

    always_comb begin
        logic scl_rise;
        logic scl_fall;
        logic start_seen;
        logic stop_seen;
        logic [7:0] rx_byte;
        logic in_page;
        logic data_byte;
        logic [AW-1:0] idx;
        logic [11:0] word;
        logic [7:0] code;
        scl_rise = 1'b0;
        scl_fall = 1'b0;
        start_seen = 1'b0;
        stop_seen = 1'b0;
        rx_byte = 8'h00;
        in_page = 1'b0;
        data_byte = 1'b0;
        idx = '0;
        word = 12'h000;
        code = 8'h00;
        next_r = r;
        next_r.scl_q = link.scl;
        next_r.sda_q = link.sda;
        next_r.cleared = 1'b0;

        // bus edges; start and stop are sda moves while scl stays high
        scl_rise = !r.scl_q && link.scl;
        scl_fall = r.scl_q && !link.scl;
        start_seen = r.scl_q && link.scl && r.sda_q && !link.sda;
        stop_seen = r.scl_q && link.scl && !r.sda_q && link.sda;
        rx_byte = {r.shreg[6:0], link.sda};
        in_page = (r.addr >> AW) == (16'(`OSDPL_PAGE_BASE) >> AW);
        data_byte = (r.byte_idx == 3'd4) || (r.byte_idx == 3'd3 && !in_page);

        if (start_seen) begin
            // repeated start restarts the byte count
            next_r.st = osdpl_pkg::D_BITS;
            next_r.bit_cnt = 4'h0;
            next_r.byte_idx = 3'd0;
            next_r.sda_oe_b = 1'b1;
        end else if (stop_seen) begin
            next_r.st = osdpl_pkg::D_IDLE;
            next_r.sda_oe_b = 1'b1;
        end else begin
            case (r.st)
                osdpl_pkg::D_IDLE: begin
                    next_r.sda_oe_b = 1'b1;
                end
                osdpl_pkg::D_BITS: begin
                    if (scl_rise && r.bit_cnt != 4'd8) begin
                        next_r.shreg = rx_byte;
                        next_r.bit_cnt = r.bit_cnt + 4'd1;
                        if (r.bit_cnt == 4'd7) begin
                            next_r.ack_pend = 1'b1;
                            if (r.byte_idx != 3'd4) begin
                                next_r.byte_idx = r.byte_idx + 3'd1;
                            end
                            case (r.byte_idx)
                                3'd0: begin
                                    next_r.ack_pend = rx_byte == `OSDPL_SLAVE_ADDR;
                                end
                                3'd1: begin
                                    next_r.addr[7:0] = rx_byte;
                                end
                                3'd2: begin
                                    next_r.addr[15:8] = rx_byte;
                                end
                                default: begin
                                    if (!data_byte) begin
                                        next_r.attr = rx_byte[3:0];
                                    end
                                end
                            endcase
                            if (data_byte) begin
                                if (in_page) begin
                                    next_r.ram[r.addr[AW-1:0]] = {rx_byte, r.attr};
                                end else if (r.addr == `OSDPL_FC_ADDR) begin
                                    next_r.fc = rx_byte;
                                    next_r.fc[`OSDPL_FC_CLEAR_BIT] = 1'b0;
                                    if (rx_byte[`OSDPL_FC_CLEAR_BIT]) begin
                                        next_r.ram = '0;
                                        next_r.cleared = 1'b1;
                                    end
                                end
                                next_r.addr = r.addr + 16'h0001;
                            end
                        end
                    end else if (scl_fall && r.bit_cnt == 4'd8) begin
                        // ack slot begins on the fall after the eighth bit
                        if (r.ack_pend) begin
                            next_r.sda_oe_b = 1'b0;
                            next_r.st = osdpl_pkg::D_ACK;
                        end else begin
                            next_r.st = osdpl_pkg::D_IGNORE;
                        end
                    end
                end
                osdpl_pkg::D_ACK: begin
                    // release on the fall that ends the ack clock
                    if (scl_fall) begin
                        next_r.sda_oe_b = 1'b1;
                        next_r.bit_cnt = 4'h0;
                        next_r.st = osdpl_pkg::D_BITS;
                    end
                end
                osdpl_pkg::D_IGNORE: begin
                    next_r.sda_oe_b = 1'b1;
                end
                default: begin
                    next_r.st = osdpl_pkg::D_IDLE;
                end
            endcase
        end

        // display walker: restart wins over step
        if (scan_restart || scan_step) begin
            if (scan_restart) begin
                // window one opens on a skip code
                idx = '0;
                next_r.sl_pos = 1'b1;
            end else begin
                idx = r.w_index + AW'(1);
                // so a trailing zero reads as skip
                next_r.sl_pos = r.w_kind == osdpl_pkg::KIND_ROW_END ||
                    r.w_kind == osdpl_pkg::KIND_WIN_END;
            end
            word = next_r.ram[idx];
            code = word[`OSDPL_CODE_MSB:`OSDPL_CODE_LSB];
            next_r.w_index = idx;
            next_r.w_code = code;
            next_r.w_attr = word[`OSDPL_ATTR_MSB:0];
            next_r.w_skip = 4'h0;
            if (next_r.sl_pos) begin
                // zero code here is zero lines
                next_r.w_kind = osdpl_pkg::KIND_SKIP;
                next_r.w_skip = word[`OSDPL_SKIP_MSB:`OSDPL_SKIP_LSB];
            end else if (code == `OSDPL_ROW_END_CODE) begin
                next_r.w_kind = osdpl_pkg::KIND_ROW_END;
                next_r.w_attr = 4'h0;
            end else if (code == `OSDPL_WIN_END_CODE) begin
                next_r.w_kind = osdpl_pkg::KIND_WIN_END;
                next_r.w_attr = 4'h0;
            end else begin
                next_r.w_kind = osdpl_pkg::KIND_CHAR;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // state register

    // memory is flops, cleared at reset as well
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            r <= '0;
            r.st <= osdpl_pkg::D_IDLE;
            r.scl_q <= 1'b1;
            r.sda_q <= 1'b1;
            r.sda_oe_b <= 1'b1;
            r.fc <= `OSDPL_FC_RESET;
            r.sl_pos <= 1'b1;
            r.w_kind <= osdpl_pkg::KIND_SKIP;
        end else begin
            r <= next_r;
        end
    end
endmodule

// [osdpl_host_end.sv]
// host end: two-entry buffer and serial transmitter of page writes
// assumes the device end on the same core_clk; scl made by a divider
`timescale 1ns/1ns
`include "osdpl_regs.svh"

module osdpl_host_end #(
    parameter logic [15:0] QUARTER = 16'(`OSDPL_SCL_QUARTER_CYC)
) (
    // clock and reset
    input wire logic core_clk,
    input wire logic rst_b,
    // serial link
    osdpl_link_if.host link,
    // transfer setup, held while the first code waits
    input wire logic [15:0] xfer_addr,
    input wire logic [3:0] xfer_attr,
    // code stream
    input wire logic [7:0] wr_data,
    input wire logic wr_last,
    input wire logic wr_valid,
    output logic wr_ready,
    // status
    output logic busy,
    output logic xfer_done,
    output logic xfer_nack
);

    typedef struct packed {
        logic [1:0][8:0] mem;
        logic wp;
        logic rp;
        logic [1:0] cnt;
        logic rdy;
        osdpl_pkg::osdpl_host_st_t st;
        logic [15:0] q;
        logic [1:0] ph;
        logic [3:0] bit_cnt;
        logic [7:0] sh;
        logic [2:0] seq;
        logic last;
        logic nack;
        logic [15:0] addr;
        logic [3:0] attr;
        logic scl_oe_b;
        logic sda_oe_b;
        logic done;
        logic bsy;
    } osdpl_host_state_t;

    osdpl_host_state_t r;
    osdpl_host_state_t next_r;

    assign link.scl_host_out = 1'b0;
    assign link.sda_host_out = 1'b0;
    assign link.scl_host_oe_b = r.scl_oe_b;
    assign link.sda_host_oe_b = r.sda_oe_b;
    assign wr_ready = r.rdy;
    assign busy = r.bsy;
    assign xfer_done = r.done;
    assign xfer_nack = r.nack;

    ////////////////////////////////////////////////////////////////////////
    // next state

    always_comb begin
        logic push;
        logic pop;
        logic tick;
        logic in_page;
        push = wr_valid && r.rdy;
        pop = 1'b0;
        tick = r.q == QUARTER - 16'd1;
        in_page = (r.addr >> 9) == (16'(`OSDPL_PAGE_BASE) >> 9);
        next_r = r;
        next_r.done = 1'b0;
        next_r.q = tick ? 16'h0000 : r.q + 16'h0001;

        case (r.st)
            osdpl_pkg::H_IDLE: begin
                next_r.q = 16'h0000;
                if (r.cnt != 2'd0) begin
                    next_r.addr = xfer_addr;
                    next_r.attr = xfer_attr;
                    next_r.sh = `OSDPL_SLAVE_ADDR;
                    next_r.seq = 3'd0;
                    next_r.last = 1'b0;
                    next_r.nack = 1'b0;
                    next_r.ph = 2'd0;
                    next_r.st = osdpl_pkg::H_START;
                end
            end
            osdpl_pkg::H_START: begin
                // sda falls with scl high, then scl falls
                if (tick) begin
                    next_r.ph = r.ph + 2'd1;
                    if (r.ph == 2'd0) begin
                        next_r.sda_oe_b = 1'b0;
                    end else begin
                        next_r.scl_oe_b = 1'b0;
                        next_r.ph = 2'd0;
                        next_r.bit_cnt = 4'h0;
                        next_r.st = osdpl_pkg::H_BYTE;
                    end
                end
            end
            osdpl_pkg::H_LOAD: begin
                // scl held low while the buffer is empty
                next_r.q = 16'h0000;
                next_r.ph = 2'd0;
                next_r.bit_cnt = 4'h0;
                next_r.st = osdpl_pkg::H_BYTE;
                case (r.seq)
                    3'd0: begin
                        next_r.sh = r.addr[7:0];
                        next_r.seq = 3'd1;
                    end
                    3'd1: begin
                        next_r.sh = r.addr[15:8];
                        next_r.seq = 3'd2;
                    end
                    3'd2: begin
                        next_r.seq = 3'd3;
                        if (in_page) begin
                            next_r.sh = {4'h0, r.attr};
                        end else begin
                            next_r.st = osdpl_pkg::H_LOAD;
                        end
                    end
                    default: begin
                        if (r.cnt != 2'd0) begin
                            pop = 1'b1;
                            next_r.sh = r.mem[r.rp][7:0];
                            next_r.last = r.mem[r.rp][8];
                            next_r.rp = !r.rp;
                        end else begin
                            next_r.st = osdpl_pkg::H_LOAD;
                        end
                    end
                endcase
            end
            osdpl_pkg::H_BYTE: begin
                if (tick) begin
                    next_r.ph = r.ph + 2'd1;
                    case (r.ph)
                        2'd0: begin
                            // data while scl low; released for the ack bit
                            next_r.sda_oe_b = r.bit_cnt == 4'd8 ? 1'b1 : r.sh[7];
                        end
                        2'd1: begin
                            next_r.scl_oe_b = 1'b1;
                        end
                        2'd2: begin
                            if (r.bit_cnt == 4'd8) begin
                                next_r.nack = link.sda;
                            end
                        end
                        default: begin
                            next_r.scl_oe_b = 1'b0;
                            next_r.sh = {r.sh[6:0], 1'b0};
                            next_r.bit_cnt = r.bit_cnt + 4'd1;
                            if (r.bit_cnt == 4'd8) begin
                                next_r.st = (r.nack || r.last) ?
                                    osdpl_pkg::H_STOP : osdpl_pkg::H_LOAD;
                            end
                        end
                    endcase
                end
            end
            osdpl_pkg::H_STOP: begin
                // sda low, scl released, then sda rises
                if (tick) begin
                    next_r.ph = r.ph + 2'd1;
                    case (r.ph)
                        2'd0: next_r.sda_oe_b = 1'b0;
                        2'd1: next_r.scl_oe_b = 1'b1;
                        default: begin
                            next_r.sda_oe_b = 1'b1;
                            next_r.done = 1'b1;
                            next_r.ph = 2'd0;
                            next_r.st = osdpl_pkg::H_IDLE;
                        end
                    endcase
                end
            end
            default: begin
                next_r.st = osdpl_pkg::H_IDLE;
            end
        endcase

        // two-entry buffer; ready drops as soon as both entries fill
        if (push) begin
            next_r.mem[r.wp] = {wr_last, wr_data};
            next_r.wp = !r.wp;
        end
        next_r.cnt = r.cnt + {1'b0, push} - {1'b0, pop};
        next_r.rdy = next_r.cnt != 2'd2;
        // busy kept in a flop so the output carries no decode glitch
        next_r.bsy = next_r.st != osdpl_pkg::H_IDLE;
    end

    ////////////////////////////////////////////////////////////////////////
    // state register

    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            r <= '0;
            r.st <= osdpl_pkg::H_IDLE;
            r.rdy <= 1'b1;
            r.scl_oe_b <= 1'b1;
            r.sda_oe_b <= 1'b1;
        end else begin
            r <= next_r;
        end
    end
endmodule

// [osdpl_link_if.sv]
// two-wire open-drain link between the host end and the device end
// resolves the wire levels from each party's output and enable
`timescale 1ns/1ns

interface osdpl_link_if;
    logic scl_host_out;
    logic scl_host_oe_b;
    logic sda_host_out;
    logic sda_host_oe_b;
    logic sda_dev_out;
    logic sda_dev_oe_b;
    logic scl;
    logic sda;

    // pulled high unless a party drives while enabled
    assign scl = scl_host_oe_b | scl_host_out;
    assign sda = (sda_host_oe_b | sda_host_out) & (sda_dev_oe_b | sda_dev_out);

    modport host (
        output scl_host_out,
        output scl_host_oe_b,
        output sda_host_out,
        output sda_host_oe_b,
        input scl,
        input sda
    );

    modport device (
        output sda_dev_out,
        output sda_dev_oe_b,
        input scl,
        input sda
    );
endinterface

// [osdpl_link_monitor.sv]
// link checker for the page ram loader serial wires
// assumes the host end runs with a quarter period of 4 core cycles
`timescale 1ns/1ns

module osdpl_link_monitor (
    // clock and reset
    input wire logic core_clk,
    input wire logic rst_b,
    // party drives and resolved wires
    input wire logic scl_host_out,
    input wire logic scl_host_oe_b,
    input wire logic sda_host_out,
    input wire logic sda_host_oe_b,
    input wire logic sda_dev_out,
    input wire logic sda_dev_oe_b,
    input wire logic scl,
    input wire logic sda
);
    logic scl_q, sda_q;
    logic [3:0] rises;
    default clocking mc @(posedge core_clk); endclocking
    default disable iff (!rst_b);
    ////////////////////////////////////////
    // scl rises since the last start; wraps to zero on the ninth rise, the ack clock
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            scl_q <= 1'b1;
            sda_q <= 1'b1;
            rises <= 4'h0;
        end else begin
            scl_q <= scl;
            sda_q <= sda;
            if (scl && scl_q && sda_q && !sda) rises <= 4'h0;
            else if (scl && !scl_q) rises <= (rises == 4'h8) ? 4'h0 : rises + 4'h1;
        end
    end
    ////////////////////////////////////////
    drive_low_a: assert property (!scl_host_out && !sda_host_out && !sda_dev_out)
        else $error("link driven high");
    ack_scl_low_a: assert property ($changed(sda_dev_oe_b) |-> !scl)
        else $error("ack moved with scl high");
    ack_slot_a: assert property ($fell(sda_dev_oe_b) |-> rises == 4'h8)
        else $error("ack outside ninth bit");
    ack_len_a: assert property ($fell(sda_dev_oe_b) |-> !sda_dev_oe_b [*8] ##[1:30] sda_dev_oe_b)
        else $error("ack length wrong");
    sda_hold_a: assert property (scl && $past(scl) && $changed(sda) |-> $changed(sda_host_oe_b))
        else $error("sda moved by device with scl high");
    scl_high_a: assert property ($rose(scl) |-> scl [*8])
        else $error("scl high too short");
    start_gap_a: assert property ($fell(sda) && scl |-> scl [*3] ##[1:10] !scl)
        else $error("start not followed by clocking");
    idle_rst_a: assert property ($rose(rst_b) |-> scl && sda && sda_dev_oe_b)
        else $error("link not idle after reset");
    // main link events
    ack_cv: cover property ($fell(sda_dev_oe_b));
    start_cv: cover property ($fell(sda) && scl);
    stop_cv: cover property ($rose(sda) && scl);
endmodule

// [osdpl_pkg.sv]
// types shared by the two ends of the page ram loader
// assumes nothing of its surroundings
package osdpl_pkg;

    // what the display walker found at the current location
    typedef enum logic [1:0] {
        KIND_SKIP,
        KIND_CHAR,
        KIND_ROW_END,
        KIND_WIN_END
    } osdpl_kind_t;

    // device end receive states
    typedef enum logic [1:0] {
        D_IDLE,
        D_BITS,
        D_ACK,
        D_IGNORE
    } osdpl_dev_st_t;

    // host end transmit states
    typedef enum logic [2:0] {
        H_IDLE,
        H_START,
        H_LOAD,
        H_BYTE,
        H_STOP
    } osdpl_host_st_t;

endpackage

// [osdpl_regs.svh]
// register offsets, code values, field positions and timing counts
// of the page ram loader; included by both ends of the serial link
`ifndef OSDPL_REGS_SVH
`define OSDPL_REGS_SVH

// device select byte sent first after the start condition
`define OSDPL_SLAVE_ADDR 8'hba
// first bus address of the page memory and of the frame control register
`define OSDPL_PAGE_BASE 16'h8000
`define OSDPL_FC_ADDR 16'h8400
`define OSDPL_FC_RESET 8'h00
`define OSDPL_FC_CLEAR_BIT 3
// control codes in the code field of a stored word
`define OSDPL_ROW_END_CODE 8'h01
`define OSDPL_WIN_END_CODE 8'h00
// word layout: code in bits 11:4, attribute in 3:0, skip count in 7:4
`define OSDPL_CODE_MSB 11
`define OSDPL_CODE_LSB 4
`define OSDPL_ATTR_MSB 3
`define OSDPL_SKIP_MSB 7
`define OSDPL_SKIP_LSB 4
// serial clock quarter period, least time, rounded up to core cycles
`define OSDPL_CLK_NS 20
`define OSDPL_SCL_QUARTER_NS 2500
`define OSDPL_SCL_QUARTER_CYC ((`OSDPL_SCL_QUARTER_NS + `OSDPL_CLK_NS - 1) / `OSDPL_CLK_NS)

`endif

// [test_osd_page_ram_loader.sv]
// bench joining the host end and the device end face to face
// assumes a 50 MHz core_clk; the host quarter is cut to 4 cycles
`timescale 1ns/1ns

module test_osd_page_ram_loader;
    logic core_clk, rst_b, wr_last, wr_valid, wr_ready, busy, xfer_done, xfer_nack;
    logic scan_restart, scan_step, page_cleared;
    logic [15:0] xfer_addr;
    logic [3:0] xfer_attr, scan_attr, scan_skip;
    logic [7:0] wr_data, scan_code, frame_control_one;
    logic [8:0] scan_index, widx;
    osdpl_pkg::osdpl_kind_t scan_kind;
    logic [7:0] q[$];
    int err_total, checked, clr_seen, stalls;
    osdpl_link_if link();
    osdpl_host_end #(.QUARTER(16'h0004)) osdpl_host_end_i (.core_clk, .rst_b, .link(link),
        .xfer_addr, .xfer_attr, .wr_data, .wr_last, .wr_valid, .wr_ready, .busy, .xfer_done,
        .xfer_nack);
    osdpl_device_end osdpl_device_end_i (.core_clk, .rst_b, .link(link), .scan_restart,
        .scan_step, .scan_index, .scan_kind, .scan_code, .scan_attr, .scan_skip,
        .frame_control_one, .page_cleared);
    osdpl_link_monitor osdpl_link_monitor_i (.core_clk, .rst_b,
        .scl_host_out(link.scl_host_out), .scl_host_oe_b(link.scl_host_oe_b),
        .sda_host_out(link.sda_host_out), .sda_host_oe_b(link.sda_host_oe_b),
        .sda_dev_out(link.sda_dev_out), .sda_dev_oe_b(link.sda_dev_oe_b),
        .scl(link.scl), .sda(link.sda));
    ////////////////////////////////////////
    // clock, and mid-cycle event counts once flops have settled
    initial begin
        core_clk = 1'b0;
        forever #10 core_clk = ~core_clk;
    end
    always @(negedge core_clk) begin
        if (page_cleared === 1'b1) clr_seen++;
        if (wr_valid && wr_ready === 1'b0) stalls++;
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            err_total++;
            $display("FAIL at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // push queue q as one transfer; ready is looked at mid-cycle to avoid races
    task automatic send(input logic [15:0] a, input logic [3:0] at);
        int n;
        @(posedge core_clk);
        xfer_addr <= a;
        xfer_attr <= at;
        for (int i = 0; i < q.size(); i++) begin
            wr_data <= q[i];
            wr_last <= (i == q.size() - 1);
            wr_valid <= 1'b1;
            @(negedge core_clk);
            while (wr_ready !== 1'b1) @(negedge core_clk);
            @(posedge core_clk);
        end
        wr_valid <= 1'b0;
        repeat (2) @(negedge core_clk);
        chk(32'(busy), 32'h1);
        n = 0;
        while (xfer_done !== 1'b1 && n < 4000) begin
            @(negedge core_clk);
            n++;
        end
        chk({busy, xfer_done, xfer_nack}, 32'h2);
    endtask
    // restart or step the walker, then compare what it shows
    task automatic walk(input logic rs, input osdpl_pkg::osdpl_kind_t k, input logic [7:0] c,
        input logic [3:0] a, input logic [3:0] s);
        widx = rs ? 9'h000 : widx + 9'h001;
        @(posedge core_clk);
        scan_restart <= rs;
        scan_step <= !rs;
        @(posedge core_clk);
        scan_restart <= 1'b0;
        scan_step <= 1'b0;
        @(posedge core_clk);
        @(negedge core_clk);
        chk({scan_index, scan_kind, scan_code, scan_attr, scan_skip},
            {widx, k, c, a, s});
    endtask
    ////////////////////////////////////////
    // one window in one stalled transfer, then a new window with a fresh attribute
    task automatic page_window();
        q = '{8'h02, 8'h41, 8'hff, 8'h01, 8'h0f, 8'h02, 8'h00};
        send(16'h8000, 4'h6);
        chk(32'(stalls > 0), 32'h1);
        q = '{8'h03};
        send(16'h8007, 4'h9);
        walk(1'b1, osdpl_pkg::KIND_SKIP, 8'h02, 4'h6, 4'h2);
        walk(1'b0, osdpl_pkg::KIND_CHAR, 8'h41, 4'h6, 4'h0);
        walk(1'b0, osdpl_pkg::KIND_CHAR, 8'hff, 4'h6, 4'h0);
        walk(1'b0, osdpl_pkg::KIND_ROW_END, 8'h01, 4'h0, 4'h0);
        walk(1'b0, osdpl_pkg::KIND_SKIP, 8'h0f, 4'h6, 4'hf);
        walk(1'b0, osdpl_pkg::KIND_CHAR, 8'h02, 4'h6, 4'h0);
        walk(1'b0, osdpl_pkg::KIND_WIN_END, 8'h00, 4'h0, 4'h0);
        walk(1'b0, osdpl_pkg::KIND_SKIP, 8'h03, 4'h9, 4'h3);
        walk(1'b0, osdpl_pkg::KIND_WIN_END, 8'h00, 4'h0, 4'h0);
    endtask
    // plain frame bits stay, the clear bit wipes the page and reads back low
    task automatic frame_clear();
        q = '{8'h15};
        send(16'h8400, 4'h0);
        chk({8'(clr_seen), frame_control_one}, 32'h0015);
        q = '{8'h1d};
        send(16'h8400, 4'h0);
        chk({8'(clr_seen), frame_control_one}, 32'h0115);
        walk(1'b1, osdpl_pkg::KIND_SKIP, 8'h00, 4'h0, 4'h0);
        walk(1'b0, osdpl_pkg::KIND_WIN_END, 8'h00, 4'h0, 4'h0);
    endtask
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", checked, err_total);
        if (err_total == 0 && checked > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    ////////////////////////////////////////
    // reset, reset values, scenarios
    initial begin
        rst_b = 1'b0;
        {xfer_addr, xfer_attr, wr_data, wr_last, wr_valid, scan_restart, scan_step} = '0;
        {err_total, checked, clr_seen, stalls} = '0;
        widx = 9'h000;
        repeat (2) @(posedge core_clk);
        rst_b <= 1'b1;
        @(negedge core_clk);
        chk({frame_control_one, wr_ready, busy, scan_index},
            {8'h00, 1'b1, 1'b0, 9'h000});
        page_window();
        frame_clear();
        wrap_up();
    end
    // watchdog far beyond the few thousand cycles the run needs
    initial begin
        #400000;
        err_total++;
        wrap_up();
    end
endmodule
